//--- hw/wdt_pkg.sv
// Shared constants, register layout and carrier types for the watchdog and wake-up block.
package wdt_pkg;
    localparam logic [1:0] addr_control = 2'h0;
    localparam logic [1:0] addr_cause = 2'h1;
    localparam logic [1:0] addr_irq_status = 2'h2;
    localparam logic [1:0] addr_irq_mask = 2'h3;
    localparam logic [7:0] control_reset = 8'h53;
    localparam int key_msb = 7;
    localparam int key_lsb = 3;
    localparam logic [4:0] key_disable = 5'h15;
    localparam logic [4:0] key_enable = 5'h0a;
    localparam int cause_key_bit = 0;
    localparam int cause_undervoltage_bit = 2;
    localparam int cause_rstkey_bit = 3;
    localparam int irq_expiry_bit = 0;
    localparam int irq_wake_bit = 1;
    localparam int irq_key_bit = 2;
    localparam int irq_pdf_bit = 3;
    // Slow clock rate and the 40 MHz system clock give the enable period.
    localparam int slow_rc_hz = 32000;
    localparam int clk_hz = 40000000;
    localparam int slow_tick_cycles = clk_hz / slow_rc_hz;
    // Delay between a bad key write and the reset it forces.
    localparam int soft_reset_delay_ns = 50000;
    localparam int soft_reset_cycles = (soft_reset_delay_ns + 24) / 25;
    localparam int counter_width = 18;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic halt;
        logic clear_wdt;
        logic ext_reset;
        logic reset_pin_select;
        logic irq_request;
        logic irq_enabled;
        logic stack_full;
        logic undervoltage;
    } core_in_t;

    typedef struct packed {
        logic asleep;
        logic power_down_flag;
        logic wdt_expiry_flag;
        logic device_reset;
        logic pc_sp_reset;
        logic resume_after_halt;
        logic take_interrupt;
    } core_out_t;
endpackage

//--- hw/slow_tick.sv
// Enable divider that turns the system clock into slow oscillator ticks.
module slow_tick #(
    parameter int period = wdt_pkg::slow_tick_cycles
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    output logic tick_out
);
    typedef struct packed {
        logic [15:0] count;
        logic tick;
    } tick_state_t;

    tick_state_t state;
    tick_state_t next_state;

    if (period < 2 || period > 65535) begin
        $error("slow_tick period out of range");
    end

    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (state.count == 16'(period - 1)) begin
            next_state.count = 16'h0000;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + 16'h0001;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick_out = state.tick;
endmodule

//--- hw/watchdog_and_wakeup.sv
// Watchdog timer, reset-cause flags and sleep wake-up logic.
module watchdog_and_wakeup #(
    parameter int port_width = 8,
    parameter int tick_period = wdt_pkg::slow_tick_cycles
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire wdt_pkg::reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    input wire wdt_pkg::core_in_t core_in,
    input wire logic [port_width-1:0] port_a_in,
    output wdt_pkg::core_out_t core_out,
    output logic irq_out
);
    localparam int counter_width_l = wdt_pkg::counter_width;

    typedef enum logic [1:0] {
        run,
        sleeping
    } mode_t;

    typedef struct packed {
        mode_t mode;
        logic [7:0] control;
        logic key_flag;
        logic rstkey_flag;
        logic undervoltage_flag;
        logic power_down_flag;
        logic wdt_expiry_flag;
        logic [port_width-1:0] port_a_wake_mask;
        logic [port_width-1:0] port_prev;
        logic irq_at_halt;
        logic [counter_width_l-1:0] count;
        logic [15:0] key_delay;
        logic key_pending;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic [7:0] rdata;
        wdt_pkg::core_out_t out;
    } state_t;

    state_t state;
    state_t next_state;
    logic tick;
    logic [4:0] key;
    logic [2:0] sel;
    logic [counter_width_l-1:0] limit;
    logic overflow;
    logic [port_width-1:0] falls;
    logic [3:0] events;

    // Checked at elaboration: the wake mask is loaded from one byte of the cause register.
    if (port_width < 1 || port_width > 8) begin
        $error("port_width must be 1 to 8");
    end

    slow_tick #(
        .period(tick_period)
    ) u_tick (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .tick_out(tick)
    );

    assign key = state.control[wdt_pkg::key_msb:wdt_pkg::key_lsb];
    assign sel = state.control[2:0];

    always_comb begin
        unique case (sel)
            3'h0: limit = 18'h000ff;
            3'h1: limit = 18'h003ff;
            3'h2: limit = 18'h00fff;
            3'h3: limit = 18'h03fff;
            3'h4: limit = 18'h07fff;
            3'h5: limit = 18'h0ffff;
            3'h6: limit = 18'h1ffff;
            3'h7: limit = 18'h3ffff;
        endcase
    end

    // Overflow only fires on a tick, so it is a one-cycle event. Greater-or-equal keeps a shortened
    // period from letting a count that is already past the new limit run on until it wraps.
    assign overflow = tick && (key == wdt_pkg::key_enable) && (state.count >= limit);
    assign falls = state.port_prev & ~port_a_in & state.port_a_wake_mask;

    always_comb begin
        next_state = state;
        next_state.out.device_reset = 1'b0;
        next_state.out.pc_sp_reset = 1'b0;
        next_state.out.resume_after_halt = 1'b0;
        next_state.out.take_interrupt = 1'b0;
        next_state.port_prev = port_a_in;
        next_state.rdata = 8'h00;
        events = 4'h0;

        if (tick && key == wdt_pkg::key_enable) begin
            next_state.count = state.count + 18'h00001;
        end

        if (core_in.clear_wdt) begin
            next_state.count = '0;
            next_state.power_down_flag = 1'b0;
        end

        if (state.mode == run) begin
            if (overflow) begin
                next_state.out.device_reset = 1'b1;
                next_state.wdt_expiry_flag = 1'b1;
                next_state.count = '0;
                events[wdt_pkg::irq_expiry_bit] = 1'b1;
            end else if (core_in.halt) begin
                next_state.mode = sleeping;
                next_state.power_down_flag = 1'b1;
                next_state.wdt_expiry_flag = 1'b0;
                next_state.count = '0;
                next_state.irq_at_halt = core_in.irq_request;
                events[wdt_pkg::irq_pdf_bit] = 1'b1;
            end
        end else begin
            if (overflow) begin
                next_state.mode = run;
                next_state.wdt_expiry_flag = 1'b1;
                next_state.out.pc_sp_reset = 1'b1;
                next_state.count = '0;
                events[wdt_pkg::irq_expiry_bit] = 1'b1;
            end else if (|falls) begin
                next_state.mode = run;
                next_state.out.resume_after_halt = 1'b1;
                events[wdt_pkg::irq_wake_bit] = 1'b1;
            end else if (core_in.irq_request && !state.irq_at_halt) begin
                next_state.mode = run;
                events[wdt_pkg::irq_wake_bit] = 1'b1;
                if (core_in.irq_enabled && !core_in.stack_full) begin
                    next_state.out.take_interrupt = 1'b1;
                end else begin
                    next_state.out.resume_after_halt = 1'b1;
                end
            end
        end

        if (!core_in.irq_request) begin
            next_state.irq_at_halt = 1'b0;
        end

        if (core_in.undervoltage) begin
            next_state.undervoltage_flag = 1'b1;
        end

        // Bad key write: count down the soft-reset delay, then reset.
        if (state.key_pending) begin
            if (state.key_delay == 16'h0000) begin
                next_state.key_pending = 1'b0;
                next_state.out.device_reset = 1'b1;
                next_state.key_flag = 1'b1;
                next_state.count = '0;
                next_state.control = wdt_pkg::control_reset;
                next_state.mode = run;
                events[wdt_pkg::irq_key_bit] = 1'b1;
            end else begin
                next_state.key_delay = state.key_delay - 16'h0001;
            end
        end

        if (reg_req_in.wr) begin
            unique case (reg_req_in.addr)
                wdt_pkg::addr_control: begin
                    next_state.control = reg_req_in.wdata;
                    if (reg_req_in.wdata[7:3] != wdt_pkg::key_enable
                        && reg_req_in.wdata[7:3] != wdt_pkg::key_disable) begin
                        next_state.key_pending = 1'b1;
                        next_state.key_delay = 16'(wdt_pkg::soft_reset_cycles - 1);
                    end
                end
                wdt_pkg::addr_cause: begin
                    // Flags clear only on a zero write; set from hardware wins.
                    if (!reg_req_in.wdata[wdt_pkg::cause_key_bit] && !next_state.key_flag) begin
                        next_state.key_flag = 1'b0;
                    end else if (!reg_req_in.wdata[wdt_pkg::cause_key_bit]
                        && !(state.key_pending && state.key_delay == 16'h0000)) begin
                        next_state.key_flag = 1'b0;
                    end
                    if (!reg_req_in.wdata[wdt_pkg::cause_rstkey_bit]) begin
                        next_state.rstkey_flag = 1'b0;
                    end
                    if (!reg_req_in.wdata[wdt_pkg::cause_undervoltage_bit] && !core_in.undervoltage) begin
                        next_state.undervoltage_flag = 1'b0;
                    end
                    next_state.port_a_wake_mask = reg_req_in.wdata[7:8-port_width];
                end
                wdt_pkg::addr_irq_status: begin
                    next_state.irq_status = state.irq_status & ~reg_req_in.wdata[3:0];
                end
                wdt_pkg::addr_irq_mask: begin
                    next_state.irq_mask = reg_req_in.wdata[3:0];
                end
            endcase
        end
        next_state.irq_status = next_state.irq_status | events;

        // External reset pin, when selected, resets the device and the counter.
        if (core_in.reset_pin_select && core_in.ext_reset) begin
            next_state.out.device_reset = 1'b1;
            next_state.count = '0;
            next_state.mode = run;
            next_state.control = wdt_pkg::control_reset;
            next_state.key_pending = 1'b0;
        end

        if (reg_req_in.rd) begin
            unique case (reg_req_in.addr)
                wdt_pkg::addr_control: next_state.rdata = state.control;
                wdt_pkg::addr_cause: begin
                    next_state.rdata = 8'h00;
                    next_state.rdata[wdt_pkg::cause_key_bit] = state.key_flag;
                    next_state.rdata[wdt_pkg::cause_undervoltage_bit] = state.undervoltage_flag;
                    next_state.rdata[wdt_pkg::cause_rstkey_bit] = state.rstkey_flag;
                end
                wdt_pkg::addr_irq_status: next_state.rdata = {4'h0, state.irq_status};
                wdt_pkg::addr_irq_mask: next_state.rdata = {4'h0, state.irq_mask};
            endcase
        end

        next_state.out.asleep = (next_state.mode == sleeping);
        next_state.out.power_down_flag = next_state.power_down_flag;
        next_state.out.wdt_expiry_flag = next_state.wdt_expiry_flag;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= '0;
            state.mode <= run;
            state.control <= wdt_pkg::control_reset;
            state.port_prev <= '1;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata_out = state.rdata;
    assign core_out = state.out;
    assign irq_out = |(state.irq_status & state.irq_mask);

    // Age of a pending bad-key reset; any control write restarts the age, though only a bad-key write reloads the delay.
    logic [15:0] pend_age;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pend_age <= 16'h0000;
        end else if (!state.key_pending || (reg_req_in.wr && reg_req_in.addr == wdt_pkg::addr_control)) begin
            pend_age <= 16'h0000;
        end else begin
            pend_age <= pend_age + 16'h0001;
        end
    end

    localparam int key_age_max = wdt_pkg::soft_reset_cycles;

    property p_halt_sets_pdf;
        @(posedge clk_in) disable iff (!arst_n_in)
        (state.mode == run && core_in.halt && !overflow && !core_in.ext_reset && !state.key_pending)
        |=> state.power_down_flag && state.mode == sleeping && state.count == '0;
    endproperty
    a_halt_sets_pdf: assert property (p_halt_sets_pdf) else $error("halt did not set power-down flag");

    property p_clear_pdf;
        @(posedge clk_in) disable iff (!arst_n_in)
        (core_in.clear_wdt && !(state.mode == run && core_in.halt)) |=> !state.power_down_flag;
    endproperty
    a_clear_pdf: assert property (p_clear_pdf) else $error("clear did not drop power-down flag");

    property p_sleep_overflow;
        @(posedge clk_in) disable iff (!arst_n_in)
        (state.mode == sleeping && overflow && !state.key_pending && !core_in.ext_reset)
        |=> core_out.pc_sp_reset && !core_out.device_reset && state.wdt_expiry_flag;
    endproperty
    a_sleep_overflow: assert property (p_sleep_overflow) else $error("sleep overflow not handled");

    property p_run_overflow;
        @(posedge clk_in) disable iff (!arst_n_in)
        (state.mode == run && overflow) |=> core_out.device_reset && state.wdt_expiry_flag;
    endproperty
    a_run_overflow: assert property (p_run_overflow) else $error("run overflow did not reset");

    property p_port_wake;
        @(posedge clk_in) disable iff (!arst_n_in)
        (state.mode == sleeping && |falls && !overflow && !state.key_pending && !core_in.ext_reset)
        |=> core_out.resume_after_halt && state.mode == run;
    endproperty
    a_port_wake: assert property (p_port_wake) else $error("port A fall did not wake");

    property p_pending_irq;
        @(posedge clk_in) disable iff (!arst_n_in)
        (state.mode == sleeping && state.irq_at_halt && core_in.irq_request && falls == '0 && !overflow)
        |=> !core_out.take_interrupt && !core_out.resume_after_halt;
    endproperty
    a_pending_irq: assert property (p_pending_irq) else $error("pending interrupt woke device");

    property p_bad_key;
        @(posedge clk_in) disable iff (!arst_n_in)
        (reg_req_in.wr && reg_req_in.addr == wdt_pkg::addr_control
        && reg_req_in.wdata[7:3] != wdt_pkg::key_enable && reg_req_in.wdata[7:3] != wdt_pkg::key_disable
        && !(core_in.reset_pin_select && core_in.ext_reset))
        |=> state.key_pending && state.key_delay == 16'(wdt_pkg::soft_reset_cycles - 1);
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("bad key did not start the reset delay");

    property p_key_fires;
        @(posedge clk_in) disable iff (!arst_n_in)
        (state.key_pending && state.key_delay == 16'h0000
        && !(reg_req_in.wr && reg_req_in.addr == wdt_pkg::addr_control))
        |=> core_out.device_reset && state.key_flag && state.control == wdt_pkg::control_reset;
    endproperty
    a_key_fires: assert property (p_key_fires) else $error("bad key delay ended without reset");

    property p_key_bound;
        @(posedge clk_in) disable iff (!arst_n_in)
        pend_age <= key_age_max;
    endproperty
    a_key_bound: assert property (p_key_bound) else $error("bad key reset pending too long");

    property p_disabled_stops;
        @(posedge clk_in) disable iff (!arst_n_in)
        (key != wdt_pkg::key_enable) |=> state.count <= $past(state.count);
    endproperty
    a_disabled_stops: assert property (p_disabled_stops) else $error("stopped watchdog counted up");

    c_sleep_overflow: cover property (@(posedge clk_in) core_out.pc_sp_reset);
    c_take_interrupt: cover property (@(posedge clk_in) core_out.take_interrupt);
    c_port_wake: cover property (@(posedge clk_in) core_out.resume_after_halt);
    c_key_reset: cover property (@(posedge clk_in) core_out.device_reset && state.key_flag);
endmodule

//--- verification/core_model.sv
// Behavioural CPU core that issues halt, watchdog clears and interrupt levels.
module core_model (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire wdt_pkg::core_out_t core_resp_in,
    output wdt_pkg::core_in_t core_req_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial core_req_out = '0;

    always @(negedge arst_n_in) begin
        core_req_out <= '0;
    end

    task automatic pulse_halt();
        @(posedge clk_in);
        core_req_out.halt <= 1'b1;
        @(posedge clk_in);
        core_req_out.halt <= 1'b0;
    endtask

    // The clear instruction restarts the count, as the halt instruction also does.
    task automatic pulse_clear();
        @(posedge clk_in);
        core_req_out.clear_wdt <= 1'b1;
        @(posedge clk_in);
        core_req_out.clear_wdt <= 1'b0;
    endtask

    task automatic set_irq(input logic en, input logic full, input logic req);
        @(posedge clk_in);
        core_req_out.irq_enabled <= en;
        core_req_out.stack_full <= full;
        core_req_out.irq_request <= req;
    endtask

    task automatic set_ext(input logic sel, input logic rst);
        @(posedge clk_in);
        core_req_out.reset_pin_select <= sel;
        core_req_out.ext_reset <= rst;
    endtask

    // A vectored request is acknowledged by its handler, so it drops at once.
    always @(posedge clk_in) begin
        if (core_resp_in.take_interrupt === 1'b1) begin
            core_req_out.irq_request <= 1'b0;
        end
    end
endmodule

//--- verification/watchdog_and_wakeup_bench.sv
// Self-checking bench for the watchdog and wake-up block.
module watchdog_and_wakeup_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int tick = 4;
    localparam int b_rst = 3;
    localparam int b_pcsp = 2;
    localparam int b_resume = 1;
    localparam int b_take = 0;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    wdt_pkg::reg_req_t req = '0;
    logic [7:0] rdata;
    logic [7:0] port_a = 8'hff;
    wdt_pkg::core_in_t core_req;
    wdt_pkg::core_out_t core_resp;
    logic irq;
    int failures = 0;
    int n_tests = 0;
    int n_rst = 0;
    int pw[3] = '{8, 10, 12};

    always #12.5 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        if (core_resp.device_reset === 1'b1) begin
            n_rst <= n_rst + 1;
        end
    end

    watchdog_and_wakeup #(.port_width(8), .tick_period(tick)) watchdog_and_wakeup_inst (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .core_in(core_req), .port_a_in(port_a), .core_out(core_resp), .irq_out(irq));

    core_model core_model_inst (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .core_resp_in(core_resp), .core_req_out(core_req));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req.wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge clk_in);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        req.rd <= 1'b0;
        #1;
        check(rdata & m, exp);
    endtask

    task automatic pins(input logic [7:0] v);
        @(posedge clk_in);
        port_a <= v;
    endtask

    // Bounded wait for a one-cycle pulse, so a missing answer cannot hang the run.
    task automatic wait_bit(input int b, input int limit, output int n);
        n = 0;
        while (n < limit && core_resp[b] !== 1'b1) begin
            @(posedge clk_in);
            #1;
            n++;
        end
    endtask

    initial begin
        repeat (60000) @(posedge clk_in);
        failures++;
        results();
    end

    initial begin
        int n;
        int r;
        int lim;
        repeat (4) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rd_chk(wdt_pkg::addr_control, 8'hff, wdt_pkg::control_reset);
        rd_chk(wdt_pkg::addr_cause, 8'h09, 8'h00);
        wr(wdt_pkg::addr_control, 8'ha8);
        rd_chk(wdt_pkg::addr_control, 8'hff, 8'ha8);
        wr(wdt_pkg::addr_cause, 8'h01);
        core_model_inst.pulse_halt();
        cyc(1);
        check(core_resp.asleep, 1);
        check(core_resp.power_down_flag, 1);
        check(core_resp.wdt_expiry_flag, 0);
        pins(8'hfd);
        cyc(10);
        check(core_resp.asleep, 1);
        pins(8'hfc);
        wait_bit(b_resume, 5, n);
        check(n < 5, 1);
        cyc(1);
        check(core_resp.asleep, 0);
        check(core_resp.power_down_flag, 1);
        pins(8'hff);
        core_model_inst.pulse_clear();
        cyc(1);
        check(core_resp.power_down_flag, 0);
        for (int i = 0; i < 3; i++) begin
            core_model_inst.set_irq(i > 0, i == 1, 1'b0);
            core_model_inst.pulse_halt();
            cyc(2);
            core_model_inst.set_irq(i > 0, i == 1, 1'b1);
            wait_bit(i == 2 ? b_take : b_resume, 5, n);
            check(n < 5, 1);
            // Let the model drop a serviced request on its own edge before the bench lowers it too.
            cyc(1);
            core_model_inst.set_irq(1'b0, 1'b0, 1'b0);
            cyc(1);
        end
        core_model_inst.set_irq(1'b0, 1'b0, 1'b1);
        core_model_inst.pulse_halt();
        cyc(20);
        check(core_resp.asleep, 1);
        pins(8'hfe);
        wait_bit(b_resume, 5, n);
        check(n < 5, 1);
        pins(8'hff);
        core_model_inst.set_irq(1'b0, 1'b0, 1'b0);
        core_model_inst.pulse_halt();
        core_model_inst.set_ext(1'b1, 1'b1);
        wait_bit(b_rst, 5, n);
        check(n < 5, 1);
        core_model_inst.set_ext(1'b1, 1'b0);
        wr(wdt_pkg::addr_control, 8'ha8);
        r = n_rst;
        cyc(1500);
        check(n_rst, r);
        wr(wdt_pkg::addr_control, 8'h50);
        core_model_inst.pulse_clear();
        repeat (3) begin
            cyc(900);
            core_model_inst.pulse_clear();
        end
        check(n_rst, r);
        for (int c = 0; c < 3; c++) begin
            lim = tick << pw[c];
            wr(wdt_pkg::addr_control, {wdt_pkg::key_enable, 3'(c)});
            core_model_inst.pulse_clear();
            wait_bit(b_rst, lim + 20, n);
            check(n >= lim - tick - 4 && n <= lim + tick + 4, 1);
            cyc(1);
            check(core_resp.wdt_expiry_flag, 1);
        end
        rd_chk(wdt_pkg::addr_irq_status, 8'h01, 8'h01);
        wr(wdt_pkg::addr_irq_mask, 8'h01);
        cyc(1);
        check(irq, 1);
        wr(wdt_pkg::addr_irq_status, 8'h01);
        cyc(1);
        check(irq, 0);
        wr(wdt_pkg::addr_irq_mask, 8'h00);
        // Halt must drop the expiry flag left by the last timeout before sleeping.
        wr(wdt_pkg::addr_control, 8'h50);
        r = n_rst;
        lim = tick << 8;
        core_model_inst.pulse_halt();
        cyc(1);
        check(core_resp.wdt_expiry_flag, 0);
        wait_bit(b_pcsp, lim + 20, n);
        check(n >= lim - tick - 6 && n <= lim + tick + 4, 1);
        cyc(1);
        check(core_resp.wdt_expiry_flag, 1);
        check(core_resp.power_down_flag, 1);
        check(n_rst, r);
        wr(wdt_pkg::addr_control, 8'h00);
        wait_bit(b_rst, wdt_pkg::soft_reset_cycles + 20, n);
        check(n >= wdt_pkg::soft_reset_cycles - 4 && n <= wdt_pkg::soft_reset_cycles + 4, 1);
        rd_chk(wdt_pkg::addr_cause, 8'h01, 8'h01);
        rd_chk(wdt_pkg::addr_control, 8'hff, wdt_pkg::control_reset);
        wr(wdt_pkg::addr_cause, 8'h01);
        rd_chk(wdt_pkg::addr_cause, 8'h01, 8'h01);
        wr(wdt_pkg::addr_cause, 8'h00);
        rd_chk(wdt_pkg::addr_cause, 8'h01, 8'h00);
        results();
    end
endmodule
